/* File: core/sfi_pkg.sv */
// Constants and types shared by the serial flash interface control block.
// Assumes a single system clock of 25 MHz that samples every pin of the serial link.
package sfi_pkg;

    // Instruction codes, first byte after select, most significant bit first.
    localparam logic [7:0] SFI_OP_UNLOCK = 8'h06;
    localparam logic [7:0] SFI_OP_RELOCK = 8'h04;
    localparam logic [7:0] SFI_OP_PAGE = 8'h02;
    localparam logic [7:0] SFI_OP_BLOCK = 8'hD8;
    localparam logic [7:0] SFI_OP_FULL = 8'hC7;
    localparam logic [7:0] SFI_OP_STATUS_WR = 8'h01;
    localparam logic [7:0] SFI_OP_STATUS_RD = 8'h05;
    localparam logic [7:0] SFI_OP_SLEEP = 8'hB9;
    localparam logic [7:0] SFI_OP_WAKE = 8'hAB;

    // Status byte layout.
    localparam int SFI_BUSY_BIT = 0;
    localparam int SFI_LATCH_BIT = 1;
    localparam int SFI_PROT_LSB = 2;
    localparam logic [2:0] SFI_PROT_RESET = 3'h0;

    // Byte counts of each instruction, taken at deselect.
    localparam logic [9:0] SFI_LEN_OP = 10'h001;
    localparam logic [9:0] SFI_LEN_STATUS_WR = 10'h002;
    localparam logic [9:0] SFI_LEN_ADDR = 10'h004;
    localparam logic [9:0] SFI_LEN_PAGE_MIN = 10'h005;
    localparam logic [8:0] SFI_PAGE_BYTES = 9'h100;

    // Internal cycle durations in microseconds and the system clock rate.
    localparam int SFI_CLK_MHZ = 25;
    localparam int SFI_T_STATUS_US = 10;
    localparam int SFI_T_PAGE_US = 1000;
    localparam int SFI_T_BLOCK_US = 100000;
    localparam int SFI_T_FULL_US = 1000000;
    localparam int SFI_FAST_SHIFT = 1;

    typedef enum logic [1:0] {SFI_PWR_STANDBY, SFI_PWR_ACTIVE, SFI_PWR_DEEP} sfi_power_t;
    typedef enum logic [2:0] {SFI_CYC_NONE, SFI_CYC_STATUS, SFI_CYC_PAGE, SFI_CYC_BLOCK,
                              SFI_CYC_FULL} sfi_cycle_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
        logic hold_n;
        logic wp_n;
        logic hv;
    } sfi_pins_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0] data;
    } sfi_word_t;

endpackage

/* File: core/sfi_serial_flash_ctrl.sv */
// Serial interface front end and operation sequencer of a serial flash device.
// Assumes all link pins are asynchronous to clk and much slower than it; the program
// data stream leaves through a two-entry buffer towards the array write logic.
// Function
// [R1] Output bits change after clock falling edge.
// [R2] Input bits sampled on clock rising edge.
// [R3] Deselected means output floats.
// [R4] Deselected stays active until internal cycle ends.
// [R5] Select low enters active power state.
// [R6] No instruction before first select falling edge.
// [R7] Hold pauses exchange, keeps interface state.
// [R8] Hold floats output, ignores clock and data.
// [R9] Hold only entered while selected.
// [R10] Logic-level protect pin freezes protect bits.
// [R11] Both clock idle levels work identically.
// [R12] Unlock then page write starts program.
// [R13] Page write: up to 256 bytes, one page.
// [R14] Master should batch bytes in one page write.
// [R15] Programming clears bits; erased byte is all ones.
// [R16] Sector and full wipes start erase cycles.
// [R17] Unlock must precede every erase.
// [R18] Busy flag shows during internal cycles.
// [R19] High voltage on protect pin selects fast mode.
// [R20] Sleep enters deep power-down until wake.
// [R21] Deep power-down ignores write instructions.
// [R22] Write latch clears at reset and completion.
// [R23] Hold edges take effect while clock low.
// [R24] Deselect during hold resets the interface.
// [R25] First eight bits form the instruction, MSB first.
`timescale 1ns/1ps
`default_nettype none
module sfi_serial_flash_ctrl
    import sfi_pkg::*;
#(
    parameter int unsigned STATUS_CYCLES = SFI_T_STATUS_US * SFI_CLK_MHZ,
    parameter int unsigned PAGE_CYCLES = SFI_T_PAGE_US * SFI_CLK_MHZ,
    parameter int unsigned BLOCK_CYCLES = SFI_T_BLOCK_US * SFI_CLK_MHZ,
    parameter int unsigned FULL_CYCLES = SFI_T_FULL_US * SFI_CLK_MHZ
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic hv_detect,
    output logic miso,
    output logic miso_oe,
    output logic busy_flag,
    output logic write_latch,
    output logic [2:0] protect_size_bits,
    output sfi_power_t power_state,
    output logic fast_mode,
    output sfi_cycle_t cycle_kind,
    output logic hold_active,
    output logic stream_overrun,
    output logic stream_valid,
    output sfi_word_t stream_word,
    input wire logic stream_ready
);

    if (STATUS_CYCLES < 4 || PAGE_CYCLES < 4 || BLOCK_CYCLES < 4 || FULL_CYCLES < 4) begin : g_bad
        $error("sfi_serial_flash_ctrl: cycle counts must be at least 4");
    end

    typedef struct packed {
        sfi_pins_t sync1;
        sfi_pins_t sync2;
        logic sclk_prev;
        logic cs_prev;
        logic armed;
        logic hold;
        logic [2:0] bit_cnt;
        logic [9:0] byte_cnt;
        logic [7:0] shift;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [2:0] new_prot;
        logic [8:0] page_bytes;
        logic [7:0] out_shift;
        logic miso;
        logic miso_oe;
        logic [2:0] prot;
        logic latch;
        logic sleep;
        logic busy;
        logic fast;
        sfi_cycle_t cycle;
        logic [31:0] timer;
        sfi_power_t power;
        logic out_valid;
        sfi_word_t out_word;
        logic spare_valid;
        sfi_word_t spare_word;
        logic overrun;
    } sfi_state_t;

    sfi_state_t s_reg;
    sfi_state_t s_next;
    sfi_pins_t pin;
    logic selected;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic exec_ok;
    logic write_ok;
    logic reading;

    function automatic logic [31:0] cycle_len(input logic [31:0] base, input logic fast);
        return fast ? (base >> SFI_FAST_SHIFT) : base;
    endfunction

    function automatic logic [7:0] status_byte(input sfi_state_t st);
        logic [7:0] b;
        b = 8'h00;
        b[SFI_BUSY_BIT] = st.busy;
        b[SFI_LATCH_BIT] = st.latch;
        b[SFI_PROT_LSB +: 3] = st.prot;
        return b;
    endfunction

    // Only the second synchroniser stage is read by any logic.
    assign pin = s_reg.sync2;
    assign cs_fall = s_reg.cs_prev && !pin.cs_n;
    assign cs_rise = !s_reg.cs_prev && pin.cs_n;
    assign selected = !pin.cs_n && s_reg.armed;
    // Both clock idle levels give the same edges, so no mode setting is needed. [R11]
    assign sclk_rise = selected && !s_reg.hold && pin.sclk && !s_reg.sclk_prev && !cs_fall;
    assign sclk_fall = selected && !s_reg.hold && !pin.sclk && s_reg.sclk_prev && !cs_fall;
    // An instruction only counts when it ends on a byte boundary outside hold. [R24]
    assign exec_ok = cs_rise && s_reg.armed && !s_reg.hold && s_reg.bit_cnt == 3'h0;
    // Writes need the latch, an idle array and no deep power-down. [R12] [R17] [R21]
    assign write_ok = exec_ok && s_reg.latch && !s_reg.busy && !s_reg.sleep;
    assign reading = s_reg.opcode == SFI_OP_STATUS_RD && s_reg.byte_cnt != 10'h000
                     && !s_reg.sleep;

    always_comb begin
        logic [7:0] byte_in;
        logic popped;
        logic push;
        byte_in = {s_reg.shift[6:0], pin.mosi};
        push = 1'b0;
        popped = s_reg.out_valid && stream_ready;
        s_next = s_reg;
        s_next.sync1 = '{cs_n: cs_n, sclk: sclk, mosi: mosi, hold_n: hold_n, wp_n: wp_n,
                         hv: hv_detect};
        s_next.sync2 = s_reg.sync1;
        s_next.sclk_prev = pin.sclk;
        s_next.cs_prev = pin.cs_n;

        // Nothing is decoded until select has been seen falling once. [R6]
        if (cs_fall) begin
            s_next.armed = 1'b1;
        end

        // Hold is entered or left only while the clock is low; deselect clears it at any clock level. [R9] [R23]
        if (pin.cs_n) begin
            s_next.hold = 1'b0;
        end else if (!pin.sclk) begin
            s_next.hold = !pin.hold_n;
        end

        // Rising clock edges shift data in; hold freezes all of this. [R2] [R7] [R8]
        if (sclk_rise) begin
            s_next.shift = byte_in;
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            if (s_reg.bit_cnt == 3'h7) begin
                if (s_reg.byte_cnt != 10'h3FF) begin
                    s_next.byte_cnt = s_reg.byte_cnt + 10'h001;
                end
                if (s_reg.byte_cnt == 10'h000) begin
                    s_next.opcode = byte_in; // [R25]
                    s_next.out_shift = status_byte(s_reg);
                end else if (reading) begin
                    s_next.out_shift = status_byte(s_reg);
                end else if (s_reg.byte_cnt < SFI_LEN_ADDR) begin
                    s_next.addr = {s_reg.addr[15:0], byte_in};
                end else if (s_reg.opcode == SFI_OP_PAGE) begin
                    // Bytes stay in one page: the low address wraps. [R13]
                    s_next.addr[7:0] = s_reg.addr[7:0] + 8'h01;
                    if (s_reg.page_bytes != SFI_PAGE_BYTES) begin
                        s_next.page_bytes = s_reg.page_bytes + 9'h001;
                    end
                    push = s_reg.latch && !s_reg.busy && !s_reg.sleep; // [R15] [R21]
                end
                if (s_reg.byte_cnt == SFI_LEN_OP && s_reg.opcode == SFI_OP_STATUS_WR) begin
                    s_next.new_prot = byte_in[SFI_PROT_LSB +: 3];
                end
            end
        end

        // Output bits move on falling edges only. [R1]
        if (sclk_fall && reading) begin
            s_next.miso = s_reg.out_shift[7];
            s_next.out_shift = {s_reg.out_shift[6:0], 1'b0};
        end
        s_next.miso_oe = selected && !s_next.hold && reading; // [R3] [R8]

        // Internal cycle countdown; completion clears busy and the latch. [R18] [R22]
        if (s_reg.busy) begin
            s_next.timer = s_reg.timer - 32'h1;
            if (s_reg.timer == 32'h1) begin
                s_next.busy = 1'b0;
                s_next.latch = 1'b0;
                s_next.cycle = SFI_CYC_NONE;
            end
        end

        if (exec_ok) begin
            unique case (s_reg.opcode)
                SFI_OP_UNLOCK: begin
                    if (s_reg.byte_cnt == SFI_LEN_OP && !s_reg.sleep && !s_reg.busy) begin
                        s_next.latch = 1'b1;
                    end
                end
                SFI_OP_RELOCK: begin
                    if (s_reg.byte_cnt == SFI_LEN_OP && !s_reg.sleep && !s_reg.busy) begin
                        s_next.latch = 1'b0; // [R22]
                    end
                end
                SFI_OP_STATUS_WR: begin
                    if (write_ok && s_reg.byte_cnt == SFI_LEN_STATUS_WR) begin
                        // A low protect pin freezes the protected-area size. [R10]
                        if (pin.wp_n) begin
                            s_next.prot = s_reg.new_prot;
                        end
                        s_next.busy = 1'b1;
                        s_next.cycle = SFI_CYC_STATUS;
                        s_next.timer = 32'(STATUS_CYCLES);
                    end
                end
                SFI_OP_PAGE: begin
                    if (write_ok && s_reg.byte_cnt >= SFI_LEN_PAGE_MIN) begin
                        s_next.busy = 1'b1; // [R12]
                        s_next.fast = pin.hv; // [R19]
                        s_next.cycle = SFI_CYC_PAGE;
                        s_next.timer = cycle_len(32'(PAGE_CYCLES), pin.hv);
                    end
                end
                SFI_OP_BLOCK: begin
                    if (write_ok && s_reg.byte_cnt == SFI_LEN_ADDR) begin
                        s_next.busy = 1'b1; // [R16]
                        s_next.fast = pin.hv; // [R19]
                        s_next.cycle = SFI_CYC_BLOCK;
                        s_next.timer = cycle_len(32'(BLOCK_CYCLES), pin.hv);
                    end
                end
                SFI_OP_FULL: begin
                    // A full wipe is refused while any area is protected.
                    if (write_ok && s_reg.byte_cnt == SFI_LEN_OP && s_reg.prot == 3'h0) begin
                        s_next.busy = 1'b1; // [R16]
                        s_next.fast = pin.hv; // [R19]
                        s_next.cycle = SFI_CYC_FULL;
                        s_next.timer = cycle_len(32'(FULL_CYCLES), pin.hv);
                    end
                end
                SFI_OP_SLEEP: begin
                    if (s_reg.byte_cnt == SFI_LEN_OP && !s_reg.busy) begin
                        s_next.sleep = 1'b1; // [R20]
                    end
                end
                SFI_OP_WAKE: begin
                    if (s_reg.byte_cnt >= SFI_LEN_OP) begin
                        s_next.sleep = 1'b0; // [R20]
                    end
                end
                default: begin
                end
            endcase
        end

        // Deselect ends the instruction and resets the interface, hold or not. [R24]
        if (pin.cs_n || cs_fall) begin
            s_next.bit_cnt = 3'h0;
            s_next.byte_cnt = 10'h000;
            s_next.page_bytes = 9'h000;
            s_next.opcode = 8'h00;
            s_next.shift = 8'h00;
        end

        if (s_next.sleep) begin
            s_next.power = SFI_PWR_DEEP;
        end else if (!pin.cs_n || s_reg.busy) begin
            s_next.power = SFI_PWR_ACTIVE; // [R4] [R5]
        end else begin
            s_next.power = SFI_PWR_STANDBY;
        end

        // Two-entry buffer: a stalled reader fills the spare slot before any loss.
        if (popped) begin
            s_next.out_valid = s_reg.spare_valid;
            s_next.out_word = s_reg.spare_word;
            s_next.spare_valid = 1'b0;
        end
        if (push) begin
            if (!s_next.out_valid) begin
                s_next.out_valid = 1'b1;
                s_next.out_word = '{addr: s_reg.addr, data: byte_in};
            end else if (!s_next.spare_valid) begin
                s_next.spare_valid = 1'b1;
                s_next.spare_word = '{addr: s_reg.addr, data: byte_in};
            end else begin
                // The link cannot be stalled, so a third byte is dropped and flagged.
                s_next.overrun = 1'b1;
            end
        end
        if (cs_fall) begin
            s_next.overrun = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_reg <= '0;
            // Select counts as low at reset so only a real falling edge arms. [R6]
            s_reg.sync1 <= '{cs_n: 1'b0, sclk: 1'b0, mosi: 1'b0, hold_n: 1'b1, wp_n: 1'b1,
                             hv: 1'b0};
            s_reg.sync2 <= '{cs_n: 1'b0, sclk: 1'b0, mosi: 1'b0, hold_n: 1'b1, wp_n: 1'b1,
                             hv: 1'b0};
            s_reg.prot <= SFI_PROT_RESET;
            s_reg.cycle <= SFI_CYC_NONE;
            s_reg.power <= SFI_PWR_STANDBY;
        end else begin
            s_reg <= s_next;
        end
    end

    assign miso = s_reg.miso;
    assign miso_oe = s_reg.miso_oe;
    assign busy_flag = s_reg.busy;
    assign write_latch = s_reg.latch;
    assign protect_size_bits = s_reg.prot;
    assign power_state = s_reg.power;
    assign fast_mode = s_reg.fast;
    assign cycle_kind = s_reg.cycle;
    assign hold_active = s_reg.hold;
    assign stream_overrun = s_reg.overrun;
    assign stream_valid = s_reg.out_valid;
    assign stream_word = s_reg.out_word;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence seq_sleep_issue;
        exec_ok && s_reg.opcode == SFI_OP_SLEEP && s_reg.byte_cnt == SFI_LEN_OP && !s_reg.busy;
    endsequence

    sequence seq_deep_entered;
        s_reg.sleep ##1 power_state == SFI_PWR_DEEP;
    endsequence

    a_float_deselect: assert property (pin.cs_n |=> !miso_oe) // [R3]
        else $error("output driven while deselected");
    a_float_in_hold: assert property (s_reg.hold |-> !miso_oe) // [R8]
        else $error("output driven during hold");
    a_sample_rising: assert property ( // [R2]
        sclk_rise |=> s_reg.bit_cnt == $past(s_reg.bit_cnt) + 3'h1)
        else $error("rising clock edge not sampled");
    a_out_on_fall: assert property (!sclk_fall |=> $stable(miso)) // [R1]
        else $error("output changed without a falling edge");
    a_unarmed_idle: assert property ( // [R6]
        !s_reg.armed |=> s_reg.byte_cnt == 10'h000 && !$rose(busy_flag))
        else $error("instruction taken before first select edge");
    a_latch_done: assert property ($fell(busy_flag) |-> !write_latch) // [R22]
        else $error("write latch survived cycle completion");
    a_sleep_blocks: assert property (s_reg.sleep && cs_rise |=> $stable(busy_flag)) // [R21]
        else $error("write accepted in deep power-down");
    a_sleep_enter: assert property (seq_sleep_issue |=> seq_deep_entered) // [R20]
        else $error("sleep instruction did not reach deep power-down");
    a_active_power: assert property ((!pin.cs_n || s_reg.busy) && !s_reg.sleep // [R4] [R5]
                                     |=> power_state == SFI_PWR_ACTIVE)
        else $error("not active while selected or busy");
    a_fast_select: assert property ($rose(busy_flag) && s_reg.cycle != SFI_CYC_STATUS // [R19]
                                    |-> fast_mode == $past(pin.hv))
        else $error("fast mode not taken from high-voltage detect");
    a_hold_needs_sel: assert property (pin.cs_n |=> !hold_active) // [R9]
        else $error("hold active while deselected");

endmodule
`default_nettype wire

/* File: test/sfi_master_model.sv */
// Bus master model that drives the serial link of the flash interface control block.
// Assumes the bench calls one task at a time; idle_level selects the clock idle level.
`timescale 1ns/1ps
`default_nettype none
module sfi_master_model (
    input wire logic clk,
    input wire logic miso,
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    output logic hold_n
);
    logic idle_level;
    initial begin
        idle_level = 1'b0;
        cs_n = 1'b0;
        sclk = 1'b0;
        mosi = 1'b0;
        hold_n = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Data changes with the falling clock so it is settled well before the rise.
    task automatic bit_io(input logic b, output logic q);
        sclk = 1'b0;
        mosi = b;
        wait_clk(4);
        sclk = 1'b1;
        q = miso;
        wait_clk(4);
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
    endtask
    task automatic select();
        sclk = idle_level;
        cs_n = 1'b1;
        wait_clk(5);
        cs_n = 1'b0;
        wait_clk(6);
    endtask
    // The data line is flipped on release so a stale bit is never mistaken for data.
    task automatic deselect();
        sclk = idle_level;
        wait_clk(4);
        cs_n = 1'b1;
        mosi = ~mosi;
        wait_clk(8);
    endtask
    // Every instruction goes whole in one frame; page data is never split.
    task automatic frame(input logic [63:0] b, input int n);
        logic [7:0] rx;
        select();
        for (int i = n - 1; i >= 0; i--) begin
            xfer(b[8 * i +: 8], rx);
        end
        deselect();
    endtask
    // Hold is moved only while selected unless a test deliberately does otherwise.
    task automatic pins(input logic hd, input logic ck);
        hold_n = hd;
        sclk = ck;
        mosi = ~mosi;
        wait_clk(8);
    endtask
endmodule
`default_nettype wire

/* File: test/test_serial_flash_interface_ctrl.sv */
// Self-checking bench for the serial flash interface control block.
// Assumes sfi_pkg and the master model are compiled first; internal cycles are shortened.
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_interface_ctrl;
    import sfi_pkg::*;
    localparam int LIMIT = 20000;
    logic clk;
    logic reset_n;
    logic wp_n;
    logic hv_detect;
    logic stream_ready;
    logic cs_n, sclk, mosi, hold_n, miso_line;
    logic miso, miso_oe, busy_flag, write_latch, fast_mode, hold_active;
    logic stream_overrun, stream_valid;
    logic [2:0] protect_size_bits;
    logic [7:0] rx;
    sfi_power_t power_state;
    sfi_cycle_t cycle_kind;
    sfi_word_t stream_word;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    // A released output reads as a toggling pattern, never as its last bit.
    assign miso_line = miso_oe ? miso : cycles[0];
    sfi_serial_flash_ctrl #(.STATUS_CYCLES(16), .PAGE_CYCLES(32), .BLOCK_CYCLES(64),
        .FULL_CYCLES(64)) dut (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
        .mosi(mosi), .hold_n(hold_n), .wp_n(wp_n), .hv_detect(hv_detect), .miso(miso),
        .miso_oe(miso_oe), .busy_flag(busy_flag), .write_latch(write_latch),
        .protect_size_bits(protect_size_bits), .power_state(power_state),
        .fast_mode(fast_mode), .cycle_kind(cycle_kind), .hold_active(hold_active),
        .stream_overrun(stream_overrun), .stream_valid(stream_valid),
        .stream_word(stream_word), .stream_ready(stream_ready));
    sfi_master_model m (.clk(clk), .miso(miso_line), .cs_n(cs_n), .sclk(sclk),
        .mosi(mosi), .hold_n(hold_n));
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares = miscompares + 1;
            finish_test();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 400 && busy_flag !== 1'b0; i++) begin
            m.wait_clk(1);
        end
        // The power state settles one cycle after busy falls.
        m.wait_clk(1);
        check("busy", busy_flag, 1'b0);
    endtask
    task automatic wipe(input logic [31:0] b, input int n, input sfi_cycle_t k, input logic hv);
        hv_detect = hv;
        m.frame({56'h0, SFI_OP_UNLOCK}, 1);
        m.frame({32'h0, b}, n);
        check("cycle", cycle_kind, k);
        check("fast", fast_mode, hv);
        wait_idle();
        check("latch", write_latch, 1'b0);
    endtask
    task automatic status_write(input logic wp, input logic [2:0] exp);
        wp_n = wp;
        m.frame({56'h0, SFI_OP_UNLOCK}, 1);
        m.frame({48'h0, SFI_OP_STATUS_WR, 8'h1C}, 2);
        check("cycle", cycle_kind, SFI_CYC_STATUS);
        wait_idle();
        check("protect", protect_size_bits, exp);
    endtask
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        wp_n = 1'b1;
        hv_detect = 1'b0;
        stream_ready = 1'b0;
        m.wait_clk(6);
        reset_n = 1'b1;
        m.wait_clk(1);
        // Select is low from power-up, so the device already counts as active.
        check("power", power_state, SFI_PWR_ACTIVE);
        check("protect", protect_size_bits, SFI_PROT_RESET);
        check("latch", write_latch, 1'b0);
        // Select has been low since power-up, so this instruction must be dropped.
        m.xfer(SFI_OP_UNLOCK, rx);
        m.deselect();
        check("latch", write_latch, 1'b0);
        done("arming");
        m.select();
        check("power", power_state, SFI_PWR_ACTIVE);
        m.xfer(SFI_OP_UNLOCK, rx);
        m.deselect();
        check("latch", write_latch, 1'b1);
        check("power", power_state, SFI_PWR_STANDBY);
        m.select();
        m.xfer(SFI_OP_STATUS_RD, rx);
        m.xfer(8'h00, rx);
        check("status", rx, 8'h02);
        check("oe", miso_oe, 1'b1);
        m.deselect();
        check("oe", miso_oe, 1'b0);
        done("unlock");
        m.idle_level = 1'b1;
        m.frame({56'h0, SFI_OP_UNLOCK}, 1);
        m.frame({8'h00, SFI_OP_PAGE, 24'h0012FE, 24'hA53C0F}, 7);
        check("busy", busy_flag, 1'b1);
        check("cycle", cycle_kind, SFI_CYC_PAGE);
        check("power", power_state, SFI_PWR_ACTIVE);
        check("overrun", stream_overrun, 1'b1);
        check("word", stream_word, {24'h0012FE, 8'hA5});
        stream_ready = 1'b1;
        m.wait_clk(1);
        check("word", stream_word, {24'h0012FF, 8'h3C});
        m.wait_clk(1);
        check("valid", stream_valid, 1'b0);
        stream_ready = 1'b0;
        wait_idle();
        check("latch", write_latch, 1'b0);
        check("power", power_state, SFI_PWR_STANDBY);
        m.frame({24'h0, SFI_OP_PAGE, 32'h00001000}, 5);
        check("busy", busy_flag, 1'b0);
        done("page");
        wipe({SFI_OP_BLOCK, 24'h3F0000}, 4, SFI_CYC_BLOCK, 1'b1);
        wipe({24'h0, SFI_OP_FULL}, 1, SFI_CYC_FULL, 1'b0);
        done("wipe");
        m.select();
        for (int i = 7; i >= 4; i--) begin
            m.bit_io(SFI_OP_UNLOCK[i], rx[0]);
        end
        m.pins(1'b0, 1'b1);
        check("hold", hold_active, 1'b0);
        m.pins(1'b0, 1'b0);
        check("hold", hold_active, 1'b1);
        check("oe", miso_oe, 1'b0);
        m.pins(1'b0, 1'b1);
        m.pins(1'b0, 1'b0);
        m.pins(1'b1, 1'b0);
        check("hold", hold_active, 1'b0);
        for (int i = 3; i >= 0; i--) begin
            m.bit_io(SFI_OP_UNLOCK[i], rx[0]);
        end
        m.deselect();
        check("latch", write_latch, 1'b1);
        m.select();
        m.xfer(SFI_OP_RELOCK, rx);
        m.pins(1'b0, 1'b0);
        check("hold", hold_active, 1'b1);
        m.deselect();
        check("hold", hold_active, 1'b0);
        check("latch", write_latch, 1'b1);
        m.pins(1'b0, 1'b0);
        check("hold", hold_active, 1'b0);
        m.pins(1'b1, 1'b1);
        done("hold");
        m.frame({56'h0, SFI_OP_SLEEP}, 1);
        check("power", power_state, SFI_PWR_DEEP);
        m.frame({24'h0, SFI_OP_PAGE, 32'h00002000}, 5);
        check("busy", busy_flag, 1'b0);
        m.frame({56'h0, SFI_OP_WAKE}, 1);
        check("power", power_state, SFI_PWR_STANDBY);
        m.frame({56'h0, SFI_OP_RELOCK}, 1);
        check("latch", write_latch, 1'b0);
        done("sleep");
        status_write(1'b0, 3'h0);
        status_write(1'b1, 3'h7);
        done("protect");
        finish_test();
    end
endmodule
`default_nettype wire
